// *** common/jtm_pkg.sv ***
// Purpose: Shared constants and mode table for the transport mode mapper
// Assumes: Two links of eight lanes, frames up to eight octets per lane
// Notes:   Mode table rows hold only the mode values this block supports

package jtm_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int LANES_PER_LINK = 8;
  localparam int LANE_W         = 64;
  localparam int LID_W          = 5;
  localparam int DID_W          = 8;
  localparam int MODE_W         = 7;
  localparam int KM1_W          = 8;
  localparam int COMP_W         = 15;
  localparam int RAW_W          = 12;
  localparam int WORD_W         = 16;
  localparam int OVR_W          = 8;
  localparam int CNT_W          = 6;
  localparam int K_W            = 10;
  localparam int CHANS          = 2;

  // ----------------------------------------------------------------
  // Framing constants
  // ----------------------------------------------------------------
  localparam logic [5:0]     DECIM_BYPASS   = 6'h01;
  localparam logic [4:0]     BYP_SLOTS      = 5'h05;
  localparam logic [6:0]     TOP_BIT        = 7'h3f;
  localparam logic [6:0]     RAW_STEP       = 7'h0c;
  localparam logic [6:0]     WORD_STEP      = 7'h10;
  localparam logic [K_W-1:0] K_MAX          = 10'h100;
  localparam logic [K_W-1:0] K_FAC_OCTETS   = 10'h008;
  localparam logic [K_W-1:0] K_FAC_BLOCKS   = 10'h020;
  localparam logic [K_W-1:0] K_ONE          = 10'h001;
  localparam logic [DID_W-1:0] DID_B_OFFSET = 8'h01;
  localparam logic [CNT_W-1:0] WPC_ONE      = 6'h01;
  localparam logic [CNT_W-1:0] WPC_TWO      = 6'h02;

  // ----------------------------------------------------------------
  // Mode table
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] num;
    logic [5:0] decim;
    logic       dual;
    logic [3:0] lanes;
    logic [3:0] mPer;
    logic [3:0] f;
    logic [2:0] s;
    logic [1:0] e;
    logic       enc64;
    logic [8:0] kMin;
    logic [3:0] kStep;
  } jtm_mode_t;

  localparam jtm_mode_t MODE_NONE = '0;
  localparam int        MODE_CNT  = 15;

  localparam jtm_mode_t MODE_TAB [MODE_CNT] = '{
    '{7'h1e, 6'h01, 1'b0, 4'h4, 4'h4, 4'h8, 3'h5, 2'h1, 1'b1, 9'h000, 4'h0},
    '{7'h1f, 6'h01, 1'b1, 4'h4, 4'h4, 4'h8, 3'h5, 2'h1, 1'b1, 9'h000, 4'h0},
    '{7'h3b, 6'h10, 1'b1, 4'h1, 4'h2, 4'h4, 3'h1, 2'h1, 1'b1, 9'h000, 4'h0},
    '{7'h3c, 6'h10, 1'b1, 4'h2, 4'h2, 4'h2, 3'h1, 2'h1, 1'b1, 9'h000, 4'h0},
    '{7'h3d, 6'h10, 1'b0, 4'h1, 4'h1, 4'h2, 3'h1, 2'h0, 1'b0, 9'h010, 4'h8},
    '{7'h3e, 6'h10, 1'b0, 4'h2, 4'h1, 4'h2, 3'h2, 2'h0, 1'b0, 9'h010, 4'h8},
    '{7'h3f, 6'h10, 1'b0, 4'h4, 4'h1, 4'h2, 3'h4, 2'h0, 1'b0, 9'h010, 4'h8},
    '{7'h40, 6'h10, 1'b0, 4'h1, 4'h1, 4'h2, 3'h1, 2'h1, 1'b1, 9'h000, 4'h0},
    '{7'h41, 6'h10, 1'b0, 4'h2, 4'h1, 4'h2, 3'h2, 2'h1, 1'b1, 9'h000, 4'h0},
    '{7'h42, 6'h20, 1'b1, 4'h1, 4'h2, 4'h4, 3'h1, 2'h0, 1'b0, 9'h008, 4'h4},
    '{7'h43, 6'h20, 1'b1, 4'h2, 4'h2, 4'h2, 3'h1, 2'h0, 1'b0, 9'h010, 4'h8},
    '{7'h44, 6'h20, 1'b1, 4'h1, 4'h2, 4'h4, 3'h1, 2'h1, 1'b1, 9'h000, 4'h0},
    '{7'h45, 6'h20, 1'b0, 4'h1, 4'h1, 4'h2, 3'h1, 2'h0, 1'b0, 9'h010, 4'h8},
    '{7'h46, 6'h20, 1'b0, 4'h2, 4'h1, 4'h2, 3'h2, 2'h0, 1'b0, 9'h010, 4'h8},
    '{7'h47, 6'h20, 1'b0, 4'h1, 4'h1, 4'h2, 3'h1, 2'h1, 1'b1, 9'h000, 4'h0}
  };

endpackage : jtm_pkg

// *** dv/jtm_rx_model.sv ***
// Purpose: Receiver model keeping lane 0 of each link per frame
// Assumes: Only the lowest lanes are wired to it
// Notes:   Merged word puts link A sample before link B sample
`timescale 1ns/100ps
module jtm_rx_model
  import jtm_pkg::*;
(
  // Frame input
  input wire logic              core_clk,
  input wire logic              frameValid,
  input wire logic [LANE_W-1:0] aLane0,
  input wire logic [LANE_W-1:0] bLane0,
  // Rebuilt samples
  output logic     [23:0]       merged
);
  logic [LANE_W-1:0] aFrm_ff;
  logic [LANE_W-1:0] bFrm_ff;
  always @(posedge core_clk) if (frameValid) begin
    aFrm_ff <= aLane0;
    bFrm_ff <= bLane0;
  end
  assign merged = {aFrm_ff[63:52], bFrm_ff[63:52]};
endmodule : jtm_rx_model

// *** dv/jtm_transport_mapper_properties.sv ***
// Purpose: Port-level checks of the transport mode mapper
// Assumes: One clock domain, reset low while active
// Notes:   Bound to the mapper from the bench top
`timescale 1ns/100ps
module jtm_props
  import jtm_pkg::*;
(
  // Clock, reset and configuration
  input wire logic              core_clk,
  input wire logic              arst_n,
  input wire logic [MODE_W-1:0] linkModeSelect,
  input wire logic [KM1_W-1:0]  multiframeLenMinusOne,
  input wire logic [DID_W-1:0]  deviceId,
  // Mapper outputs
  input wire logic              smpReady,
  input wire logic              frameValid,
  input wire logic              mfBoundary,
  input wire logic [7:0]        linkALaneEn,
  input wire logic [7:0]        linkBLaneEn,
  input wire logic [DID_W-1:0]  linkADid,
  input wire logic [DID_W-1:0]  linkBDid,
  input wire logic              modeValid,
  input wire logic              enc64b66b,
  input wire logic [3:0]        lanesPerLink,
  input wire logic [3:0]        octetsPerFrame,
  input wire logic [1:0]        blocksPerMb,
  input wire logic [K_W-1:0]    multiframeLen,
  input wire logic              multiframeLenOk
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_did_a_eq: assert property (1 |=> linkADid == $past(deviceId))
    else $error("link A id wrong");
  a_did_b_inc: assert property (1 |=>
    linkBDid == $past(deviceId) + 8'h01)
    else $error("link B id wrong");
  // Lane enables and K lag the mode table fields by one cycle
  a_lane_en_low: assert property (linkBLaneEn == linkALaneEn &&
    linkALaneEn == 8'((9'h001 << $past(lanesPerLink)) - 9'h001))
    else $error("lane enables wrong");
  a_invalid_idle: assert property (!modeValid |->
    !smpReady ##1 (multiframeLen == '0 && linkALaneEn == '0))
    else $error("invalid mode not idle");
  a_mode_restart: assert property (linkModeSelect != $past(linkModeSelect)
    |-> !smpReady)
    else $error("ready during mode change");
  a_k_from_ef: assert property ($past(modeValid && enc64b66b) |->
    multiframeLenOk && multiframeLen ==
    K_W'((12'h100 * $past(blocksPerMb)) / $past(octetsPerFrame)))
    else $error("64b66b multiframe length wrong");
  a_k_minus_one: assert property ($past(modeValid && !enc64b66b) |->
    multiframeLen == $past(multiframeLenMinusOne) + K_ONE)
    else $error("8b10b multiframe length wrong");
  a_mf_in_frame: assert property (mfBoundary |-> frameValid)
    else $error("boundary outside frame");
  c_frame: cover property (frameValid);
  c_boundary: cover property (mfBoundary);
  c_bad_mode: cover property (modeValid ##1 !modeValid);
endmodule : jtm_props

// *** dv/jtm_transport_mapper_tb_top.sv ***
// Purpose: Directed scenarios for the transport mode mapper
// Assumes: Mode held while streaming
// Notes:   Checks taken just after the edge that loads the frame
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t %h %h", $time, a, b); end end
module jtm_transport_mapper_tb_top
  import jtm_pkg::*;
;
  logic core_clk = 0, arst_n = 0, smpValid = 0;
  logic smpReady, frameValid, mfBoundary, modeValid, enc64b66b, dualChan;
  logic multiframeLenOk;
  logic [MODE_W-1:0] linkModeSelect = '0;
  logic [KM1_W-1:0] multiframeLenMinusOne = '0;
  logic [DID_W-1:0] deviceId = '0, linkADid, linkBDid;
  logic [7:0] overrangeThresholdZero = 8'h40, overrangeThresholdOne = 8'h80;
  logic [7:0] chanAPeak = '0, chanBPeak = '0, linkALaneEn, linkBLaneEn;
  logic [RAW_W-1:0] chanARaw = '0, chanBRaw = '0;
  logic [COMP_W-1:0] chanAI = '0, chanAQ = '0, chanBI = '0, chanBQ = '0;
  logic [7:0][LANE_W-1:0] linkALane, linkBLane;
  logic [7:0][LID_W-1:0] linkALaneId, linkBLaneId;
  logic [5:0] decimFactor;
  logic [3:0] lanesPerLink, convPerLink, octetsPerFrame;
  logic [2:0] samplesPerFrame;
  logic [1:0] blocksPerMb;
  logic [K_W-1:0] multiframeLen;
  logic [23:0] merged;
  int n_errors = 0, n_checks = 0;
  always #50 core_clk = ~core_clk;
  jtm_transport_mapper dut_u (.*);
  jtm_rx_model rx_u (.core_clk, .frameValid, .aLane0(linkALane[0]),
    .bLane0(linkBLane[0]), .merged);
  task setm(input logic [6:0] m, input logic [7:0] k);
    @(posedge core_clk);
    {linkModeSelect, multiframeLenMinusOne, smpValid} <= {m, k, 1'b0};
    repeat (3) @(posedge core_clk);
    #1;
  endtask : setm
  task put(input logic [14:0] ai, aq, bi, bq, input logic [7:0] pa, pb);
    @(posedge core_clk);
    {chanAI, chanAQ, chanBI, chanBQ, chanAPeak, chanBPeak} <=
      {ai, aq, bi, bq, pa, pb};
    smpValid <= 1'b1;
  endtask : put
  task fin;
    @(posedge core_clk);
    smpValid <= 1'b0;
    #1;
  endtask : fin
  task t_single;
    setm(7'h3e, 8'h0f);
    deviceId <= 8'hff;
    put(15'h1234, 15'h0abc, 0, 0, 8'h81, 0);
    put(15'h7fff, 15'h0001, 0, 0, 8'h40, 0);
    fin;
    `CHK({frameValid, mfBoundary}, 2'b11)
    `CHK(linkALane[0], {15'h1234, 1'b1, 48'h0})
    `CHK(linkALane[1], {15'h7fff, 1'b0, 48'h0})
    `CHK(linkBLane[0], {15'h0abc, 1'b1, 48'h0})
    `CHK(linkBLane[1], {15'h0001, 1'b0, 48'h0})
    `CHK({linkALaneEn, linkBLaneEn}, 16'h0303)
    `CHK({linkADid, linkBDid}, 16'hff00)
    `CHK({multiframeLen, multiframeLenOk}, {10'h010, 1'b1})
    setm(7'h3e, 8'h10);
    `CHK(multiframeLenOk, 1'b0)
    $display("single decimating mode done");
  endtask : t_single
  task t_dual;
    setm(7'h3b, 8'h00);
    put(15'h2aaa, 15'h5555, 15'h0f0f, 15'h7000, 8'h60, 8'h81);
    fin;
    `CHK(linkALane[0], {15'h2aaa, 1'b1, 15'h5555, 1'b0, 32'h0})
    `CHK(linkBLane[0], {15'h0f0f, 1'b1, 15'h7000, 1'b1, 32'h0})
    `CHK({multiframeLen, multiframeLenOk}, {10'h040, 1'b1})
    `CHK({dualChan, samplesPerFrame, enc64b66b}, 5'h13)
    $display("dual decimating mode done");
  endtask : t_dual
  task t_bypass;
    setm(7'h1e, 8'h00);
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk);
      {chanARaw, chanBRaw} <= {12'ha00 + 12'(i), 12'h500 + 12'(i)};
      smpValid <= 1'b1;
    end
    fin;
    `CHK(linkALane[0], {48'ha00a04a08a0c, 12'ha10, 4'h0})
    `CHK(linkBLane[3], {48'h50350750b50f, 12'h513, 4'h0})
    `CHK({convPerLink, lanesPerLink, multiframeLen}, {8'h44, 10'h020})
    @(posedge core_clk);
    #1;
    `CHK(merged, 24'ha00500)
    $display("bypass mode done");
  endtask : t_bypass
  task t_modes;
    for (int m = 59; m < 72; m++) begin
      setm(7'(m), 8'h0f);
      `CHK({modeValid, decimFactor}, {1'b1, (m < 66) ? 6'h10 : 6'h20})
    end
    for (int i = 0; i < 8; i++)
      `CHK({linkALaneId[i], linkBLaneId[i]}, {5'(i), 5'(i)})
    setm(7'h48, 8'h00);
    `CHK({modeValid, smpReady, linkALaneEn}, 10'h000)
    $display("mode list done");
  endtask : t_modes
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    t_single;
    t_dual;
    t_bypass;
    t_modes;
    report_and_stop;
  end
  initial begin
    #300000;
    n_errors++;
    report_and_stop;
  end
endmodule : jtm_transport_mapper_tb_top
bind jtm_transport_mapper jtm_props props_u (.*);

// *** rtl/jtm_mode_table.sv ***
// Purpose: Looks up the framing parameters of one mode-select value
// Assumes: Mode select is stable for the cycle it is read
// Notes:   Unlisted values give an all-zero entry and no hit

`timescale 1ns/100ps

module jtm_mode_table
  import jtm_pkg::*;
(
  // Mode select
  input  wire logic [MODE_W-1:0] modeSel,
  // Table answer
  output jtm_mode_t              entry,
  output logic                   hit
);

  always_comb begin
    entry = MODE_NONE;
    hit   = 1'b0;
    for (int i = 0; i < MODE_CNT; i++) begin
      if (MODE_TAB[i].num == modeSel) begin
        entry = MODE_TAB[i];
        hit   = 1'b1;
      end
    end
  end

endmodule : jtm_mode_table

// *** rtl/jtm_transport_mapper.sv ***
// Purpose: Maps samples into lane frames on two links for one link mode
// Assumes: One accepted sample set per cycle, mode held while streaming
// Notes:   Frames leave whole, one lane word per lane per frame
//
// What this block does
// - All framing parameters but the 8b/10b K come from one mode value; unlisted values are invalid.
// - Modes 30, 31 and 59 to 71 pick decimation, channels, lanes and encoding.
// - 8b/10b modes take K from the minus-one field within min, step, max.
// - 64b/66b modes compute K as 8 times 32 times E over F.
// - Marked modes use M equal to L, samples in time order over lanes.
// - Sixteen lanes as two links of eight; every mode uses both links.
// - Lowest lanes of each link are driven; higher unused lanes power down.
// - Link A advertises the programmed device identifier.
// - Link B advertises the programmed device identifier plus one.
// - Lane identifier equals lane index within its link, 0 to 7.
// - Without decimation, 12-bit offset-binary samples are packed into octets.
// - With decimation, words are 15-bit components plus one overrange bit.
// - Every tail bit of every frame is zero.
// - Samples are placed most significant bit first.
// - Single-channel first overrange flag is set above the first threshold.
// - Single-channel second overrange flag is set above the second threshold.
// - Dual-channel channel A flags follow the first and second thresholds.
// - Dual-channel channel B flags follow the first and second thresholds.

`timescale 1ns/100ps

module jtm_transport_mapper
  import jtm_pkg::*;
#(
  parameter int OVR_WIDTH = OVR_W
) (
  // Clock and reset
  input  wire logic                                     core_clk,
  input  wire logic                                     arst_n,
  // Mode and link configuration
  input  wire logic [MODE_W-1:0]                        linkModeSelect,
  input  wire logic [KM1_W-1:0]                         multiframeLenMinusOne,
  input  wire logic [DID_W-1:0]                         deviceId,
  input  wire logic [OVR_WIDTH-1:0]                     overrangeThresholdZero,
  input  wire logic [OVR_WIDTH-1:0]                     overrangeThresholdOne,
  // Sample input
  input  wire logic                                     smpValid,
  output logic                                          smpReady,
  input  wire logic [RAW_W-1:0]                         chanARaw,
  input  wire logic [RAW_W-1:0]                         chanBRaw,
  input  wire logic [COMP_W-1:0]                        chanAI,
  input  wire logic [COMP_W-1:0]                        chanAQ,
  input  wire logic [COMP_W-1:0]                        chanBI,
  input  wire logic [COMP_W-1:0]                        chanBQ,
  input  wire logic [OVR_WIDTH-1:0]                     chanAPeak,
  input  wire logic [OVR_WIDTH-1:0]                     chanBPeak,
  // Frame output
  output logic                                          frameValid,
  output logic                                          mfBoundary,
  output logic [LANES_PER_LINK-1:0][LANE_W-1:0]         linkALane,
  output logic [LANES_PER_LINK-1:0][LANE_W-1:0]         linkBLane,
  // Lane control
  output logic [LANES_PER_LINK-1:0]                     linkALaneEn,
  output logic [LANES_PER_LINK-1:0]                     linkBLaneEn,
  output logic [DID_W-1:0]                              linkADid,
  output logic [DID_W-1:0]                              linkBDid,
  output logic [LANES_PER_LINK-1:0][LID_W-1:0]          linkALaneId,
  output logic [LANES_PER_LINK-1:0][LID_W-1:0]          linkBLaneId,
  // Derived parameters
  output logic                                          modeValid,
  output logic                                          enc64b66b,
  output logic [5:0]                                    decimFactor,
  output logic                                          dualChan,
  output logic [3:0]                                    lanesPerLink,
  output logic [3:0]                                    convPerLink,
  output logic [3:0]                                    octetsPerFrame,
  output logic [2:0]                                    samplesPerFrame,
  output logic [1:0]                                    blocksPerMb,
  output logic [K_W-1:0]                                multiframeLen,
  output logic                                          multiframeLenOk
);

  // ----------------------------------------------------------------
  // Mode lookup
  // ----------------------------------------------------------------
  jtm_mode_t         tabEntry;
  logic              tabHit;
  jtm_mode_t         cfg_ff;
  logic              modeOk_ff;
  logic [MODE_W-1:0] modeSel_ff;
  logic              restart;

  jtm_mode_table u_mode_table (
    .modeSel (linkModeSelect),
    .entry   (tabEntry),
    .hit     (tabHit)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff     <= MODE_NONE;
      modeOk_ff  <= 1'b0;
      modeSel_ff <= '0;
    end else begin
      cfg_ff     <= tabHit ? tabEntry : MODE_NONE;
      modeOk_ff  <= tabHit;
      modeSel_ff <= linkModeSelect;
    end
  end

  // A new mode value discards the partial frame
  assign restart = linkModeSelect != modeSel_ff;

  // ----------------------------------------------------------------
  // Channel word forming
  // ----------------------------------------------------------------
  logic [CHANS-1:0][COMP_W-1:0]    compI;
  logic [CHANS-1:0][COMP_W-1:0]    compQ;
  logic [CHANS-1:0][RAW_W-1:0]     rawIn;
  logic [CHANS-1:0][OVR_WIDTH-1:0] peakIn;
  logic [CHANS-1:0][WORD_W-1:0]    wordI;
  logic [CHANS-1:0][WORD_W-1:0]    wordQ;
  logic [CHANS-1:0][WORD_W-1:0]    wordRaw;

  assign compI  = {chanBI, chanAI};
  assign compQ  = {chanBQ, chanAQ};
  assign rawIn  = {chanBRaw, chanARaw};
  assign peakIn = {chanBPeak, chanAPeak};

  for (genvar ch = 0; ch < CHANS; ch++) begin : g_chan
    jtm_word_pack #(
      .OVR_WIDTH (OVR_WIDTH)
    ) u_word_pack (
      .compI   (compI[ch]),
      .compQ   (compQ[ch]),
      .raw     (rawIn[ch]),
      .peak    (peakIn[ch]),
      .thrZero (overrangeThresholdZero),
      .thrOne  (overrangeThresholdOne),
      .wordI   (wordI[ch]),
      .wordQ   (wordQ[ch]),
      .wordRaw (wordRaw[ch])
    );
  end

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  logic             bypass;
  logic             twoPerCycle;
  logic [1:0]       laneShift;
  logic [4:0]       slotsPerLane;
  logic [CNT_W-1:0] wordsPerFrame;
  logic [CNT_W-1:0] wordsPerCycle;

  assign bypass       = cfg_ff.decim == DECIM_BYPASS;
  assign twoPerCycle  = !bypass && cfg_ff.dual;
  assign slotsPerLane = bypass ? BYP_SLOTS : {2'b00, cfg_ff.f[3:1]};
  assign wordsPerCycle = twoPerCycle ? WPC_TWO : WPC_ONE;
  assign wordsPerFrame = CNT_W'({1'b0, slotsPerLane} << laneShift);

  always_comb begin
    case (cfg_ff.lanes)
      4'h2:    laneShift = 2'h1;
      4'h4:    laneShift = 2'h2;
      4'h8:    laneShift = 2'h3;
      default: laneShift = 2'h0;
    endcase
  end

  // Word idx goes to lane idx mod L, slot idx div L: time order across
  // lanes, so the receiver only interleaves lanes to restore order
  function automatic logic [LANES_PER_LINK-1:0][LANE_W-1:0] place(
    input logic [LANES_PER_LINK-1:0][LANE_W-1:0] frm,
    input logic [CNT_W-1:0]                      idx,
    input logic [1:0]                            sh,
    input logic                                  byp,
    input logic [WORD_W-1:0]                     w
  );
    logic [CNT_W-1:0] mask;
    logic [2:0]       lane;
    logic [2:0]       slot;
    logic [6:0]       base;
    mask = CNT_W'((WPC_ONE << sh) - WPC_ONE);
    lane = 3'(idx & mask);
    slot = 3'(idx >> sh);
    place = frm;
    if (byp) begin
      base = TOP_BIT - 7'(slot * RAW_STEP);
      place[lane][base -: RAW_W] = w[WORD_W-1 -: RAW_W];
    end else begin
      base = TOP_BIT - 7'(slot * WORD_STEP);
      place[lane][base -: WORD_W] = w;
    end
  endfunction : place

  // ----------------------------------------------------------------
  // Frame assembly
  // ----------------------------------------------------------------
  logic [LANES_PER_LINK-1:0][LANE_W-1:0] buildA_ff;
  logic [LANES_PER_LINK-1:0][LANE_W-1:0] buildB_ff;
  logic [LANES_PER_LINK-1:0][LANE_W-1:0] nxt_buildA;
  logic [LANES_PER_LINK-1:0][LANE_W-1:0] nxt_buildB;
  logic [WORD_W-1:0]                     wA0;
  logic [WORD_W-1:0]                     wA1;
  logic [WORD_W-1:0]                     wB0;
  logic [WORD_W-1:0]                     wB1;
  logic [CNT_W-1:0]                      wordCnt_ff;
  logic                                  accept;
  logic                                  endOfFrame;

  assign smpReady   = modeOk_ff && !restart;
  assign accept     = smpValid && smpReady;
  assign endOfFrame = accept && (wordCnt_ff + wordsPerCycle == wordsPerFrame);

  always_comb begin
    if (bypass) begin
      wA0 = wordRaw[0];
      wA1 = wordRaw[0];
      wB0 = wordRaw[1];
      wB1 = wordRaw[1];
    end else if (cfg_ff.dual) begin
      wA0 = wordI[0];
      wA1 = wordQ[0];
      wB0 = wordI[1];
      wB1 = wordQ[1];
    end else begin
      wA0 = wordI[0];
      wA1 = wordI[0];
      wB0 = wordQ[0];
      wB1 = wordQ[0];
    end
  end

  always_comb begin
    nxt_buildA = buildA_ff;
    nxt_buildB = buildB_ff;
    if (accept) begin
      nxt_buildA = place(nxt_buildA, wordCnt_ff, laneShift, bypass, wA0);
      nxt_buildB = place(nxt_buildB, wordCnt_ff, laneShift, bypass, wB0);
      if (twoPerCycle) begin
        nxt_buildA = place(nxt_buildA, wordCnt_ff + WPC_ONE, laneShift,
                           bypass, wA1);
        nxt_buildB = place(nxt_buildB, wordCnt_ff + WPC_ONE, laneShift,
                           bypass, wB1);
      end
    end
  end

  // Cleared each frame so tail bits and unused lanes stay zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      buildA_ff <= '0;
      buildB_ff <= '0;
    end else if (restart || endOfFrame) begin
      buildA_ff <= '0;
      buildB_ff <= '0;
    end else begin
      buildA_ff <= nxt_buildA;
      buildB_ff <= nxt_buildB;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wordCnt_ff <= '0;
    end else if (restart || endOfFrame) begin
      wordCnt_ff <= '0;
    end else if (accept) begin
      wordCnt_ff <= wordCnt_ff + wordsPerCycle;
    end
  end

  // ----------------------------------------------------------------
  // Frame output and multiframe position
  // ----------------------------------------------------------------
  logic                                  frameValid_ff;
  logic                                  mfBoundary_ff;
  logic [LANES_PER_LINK-1:0][LANE_W-1:0] laneA_ff;
  logic [LANES_PER_LINK-1:0][LANE_W-1:0] laneB_ff;
  logic [K_W-1:0]                        mfFrameCnt_ff;
  logic [K_W-1:0]                        kProg;
  logic [K_W-1:0]                        kCalc;
  logic [K_W-1:0]                        kOffs;
  logic [K_W-1:0]                        kStepMask;
  logic                                  kOk;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      laneA_ff <= '0;
      laneB_ff <= '0;
    end else if (endOfFrame) begin
      laneA_ff <= nxt_buildA;
      laneB_ff <= nxt_buildB;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frameValid_ff <= 1'b0;
      mfBoundary_ff <= 1'b0;
      mfFrameCnt_ff <= '0;
    end else if (restart) begin
      frameValid_ff <= 1'b0;
      mfBoundary_ff <= 1'b0;
      mfFrameCnt_ff <= '0;
    end else begin
      frameValid_ff <= endOfFrame;
      mfBoundary_ff <= endOfFrame && (mfFrameCnt_ff == '0);
      if (endOfFrame) begin
        if (mfFrameCnt_ff + K_ONE >= kCalc) begin
          mfFrameCnt_ff <= '0;
        end else begin
          mfFrameCnt_ff <= mfFrameCnt_ff + K_ONE;
        end
      end
    end
  end

  // Minus-one field for 8b/10b, fixed by E and F for 64b/66b
  assign kProg     = K_W'(multiframeLenMinusOne) + K_ONE;
  assign kOffs     = kProg - K_W'(cfg_ff.kMin);
  assign kStepMask = K_W'(cfg_ff.kStep) - K_ONE;

  always_comb begin
    if (!modeOk_ff || cfg_ff.f == 4'h0) begin
      kCalc = '0;
      kOk   = 1'b0;
    end else if (cfg_ff.enc64) begin
      kCalc = K_W'((K_FAC_OCTETS * K_FAC_BLOCKS * K_W'(cfg_ff.e))
                   / K_W'(cfg_ff.f));
      kOk   = 1'b1;
    end else begin
      kCalc = kProg;
      kOk   = kProg >= K_W'(cfg_ff.kMin) && kProg <= K_MAX
              && (kOffs & kStepMask) == '0;
    end
  end

  // ----------------------------------------------------------------
  // Lane control and identifiers
  // ----------------------------------------------------------------
  logic [LANES_PER_LINK:0]   laneMask;
  logic [LANES_PER_LINK-1:0] laneEn_ff;
  logic [DID_W-1:0]          didA_ff;
  logic [DID_W-1:0]          didB_ff;
  logic [K_W-1:0]            kLen_ff;
  logic                      kOk_ff;

  assign laneMask = ((LANES_PER_LINK + 1)'(1) << cfg_ff.lanes)
                    - (LANES_PER_LINK + 1)'(1);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      laneEn_ff <= '0;
      didA_ff   <= '0;
      didB_ff   <= '0;
      kLen_ff   <= '0;
      kOk_ff    <= 1'b0;
    end else begin
      laneEn_ff <= modeOk_ff ? laneMask[LANES_PER_LINK-1:0] : '0;
      didA_ff   <= deviceId;
      didB_ff   <= deviceId + DID_B_OFFSET;
      kLen_ff   <= kCalc;
      kOk_ff    <= kOk;
    end
  end

  for (genvar ln = 0; ln < LANES_PER_LINK; ln++) begin : g_lid
    assign linkALaneId[ln] = LID_W'(ln);
    assign linkBLaneId[ln] = LID_W'(ln);
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign frameValid      = frameValid_ff;
  assign mfBoundary      = mfBoundary_ff;
  assign linkALane       = laneA_ff;
  assign linkBLane       = laneB_ff;
  // Both links share one lane count
  assign linkALaneEn     = laneEn_ff;
  assign linkBLaneEn     = laneEn_ff;
  assign linkADid        = didA_ff;
  assign linkBDid        = didB_ff;
  assign modeValid       = modeOk_ff;
  assign enc64b66b       = cfg_ff.enc64;
  assign decimFactor     = cfg_ff.decim;
  assign dualChan        = cfg_ff.dual;
  assign lanesPerLink    = cfg_ff.lanes;
  assign convPerLink     = cfg_ff.mPer;
  assign octetsPerFrame  = cfg_ff.f;
  assign samplesPerFrame = cfg_ff.s;
  assign blocksPerMb     = cfg_ff.e;
  assign multiframeLen   = kLen_ff;
  assign multiframeLenOk = kOk_ff;

endmodule : jtm_transport_mapper

// *** rtl/jtm_word_pack.sv ***
// Purpose: Forms the transported words of one channel
// Assumes: Raw samples already arrive as offset binary
// Notes:   I word carries the first flag, Q word the second

`timescale 1ns/100ps

module jtm_word_pack
  import jtm_pkg::*;
#(
  parameter int OVR_WIDTH = OVR_W
) (
  // Sample in
  input  wire logic [COMP_W-1:0]    compI,
  input  wire logic [COMP_W-1:0]    compQ,
  input  wire logic [RAW_W-1:0]     raw,
  input  wire logic [OVR_WIDTH-1:0] peak,
  // Thresholds
  input  wire logic [OVR_WIDTH-1:0] thrZero,
  input  wire logic [OVR_WIDTH-1:0] thrOne,
  // Words out
  output logic      [WORD_W-1:0]    wordI,
  output logic      [WORD_W-1:0]    wordQ,
  output logic      [WORD_W-1:0]    wordRaw
);

  logic overFlagZero;
  logic overFlagOne;

  assign overFlagZero = peak > thrZero;
  assign overFlagOne  = peak > thrOne;
  // Component MSB first, overrange bit in the last position
  assign wordI   = {compI, overFlagZero};
  assign wordQ   = {compQ, overFlagOne};
  // Raw sample left aligned, low nibble unused
  assign wordRaw = {raw, {(WORD_W - RAW_W){1'b0}}};

endmodule : jtm_word_pack
